// >>> rtl/slc_top.sv
// serial link control register bank top
module slc_top
  import slc_pkg::*;
(
  // clocking
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic          ce,
  // register port
  input  wire logic [11:0]   addr,
  input  wire logic [7:0]    wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic [7:0]         rdata,
  // multiframe framing
  input  wire logic          sysref,
  input  wire logic          is_64b66b,
  input  wire logic [7:0]    mode_e,
  input  wire logic [7:0]    mode_f,
  // sample stream
  input  wire slc_pkg::slc_sample_type smp_in,
  output slc_pkg::slc_word_type        word_out,
  // link control outputs
  output slc_pkg::slc_ctrl_type        ctrl,
  output logic [9:0]         mf_count,
  output logic               mf_edge
);
  import slc_pkg::*;

  typedef struct packed {
    logic [9:0]   cnt;
    logic         edge_p;
    slc_ctrl_type ctrl;
  } slc_top_state_type;

  slc_top_state_type st_r;
  slc_top_state_type st_nxt;

  logic [7:0] lsb_ctrl;
  logic [7:0] link_en_reg;
  logic [7:0] mode_reg;
  logic [7:0] km1_reg;
  slc_bus_type bus;

  // effective k minus one, 256*e/f for 64b/66b
  function automatic logic [7:0] k_eff_m1(input logic b66, input logic [7:0] km1,
                                          input logic [7:0] e, input logic [7:0] f);
    logic [15:0] prod;
    logic [15:0] q;
    prod = 16'(BLOCK_FACTOR * e);
    q = (f == 8'h00) ? 16'h0100 : prod / {8'h00, f};
    if (!b66) begin
      return km1;
    end
    // k above 256 saturates to the 8-bit field
    if (q == 16'h0000) begin
      return 8'h00;
    end
    return (q > 16'h0100) ? 8'hff : 8'(q - 16'h0001);
  endfunction

  assign bus = '{wr: wr, rd: rd, addr: addr, wdata: wdata};

  slc_regs u_regs (
    .clk         (clk),
    .resetn      (resetn),
    .ce          (ce),
    .bus         (bus),
    .rdata       (rdata),
    .lsb_ctrl    (lsb_ctrl),
    .link_en_reg (link_en_reg),
    .mode_reg    (mode_reg),
    .km1_reg     (km1_reg)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.ctrl.link_rst_n = link_en_reg[BIT_LINK_EN];
    st_nxt.ctrl.serdes_pd = ~link_en_reg[BIT_LINK_EN];
    st_nxt.ctrl.clk_gate_en = link_en_reg[BIT_LINK_EN];
    st_nxt.ctrl.mode = mode_reg[MODE_LO +: MODE_W];
    st_nxt.ctrl.ts_insert = lsb_ctrl[BIT_TS_INSERT];
    st_nxt.ctrl.k_eff_m1 = k_eff_m1(is_64b66b, km1_reg, mode_e, mode_f);
    st_nxt.ctrl.ila_cs_zero = 1'b1;
    st_nxt.edge_p = 1'b0;
    st_nxt.ctrl.mfc_rst = ~link_en_reg[BIT_LINK_EN];
    if (!link_en_reg[BIT_LINK_EN]) begin
      st_nxt.cnt = 10'h000;
    end else if (sysref) begin
      // realign only while link is live
      st_nxt.cnt = 10'h000;
      st_nxt.edge_p = 1'b1;
    end else if (st_r.cnt[7:0] == st_r.ctrl.k_eff_m1) begin
      st_nxt.cnt = 10'h000;
      st_nxt.edge_p = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 10'h001;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{cnt: 10'h000, edge_p: 1'b0,
               ctrl: '{link_rst_n: 1'b1, serdes_pd: 1'b0, clk_gate_en: 1'b1, mfc_rst: 1'b0,
                       ts_insert: 1'b0, mode: 6'h00, k_eff_m1: 8'h1f, ila_cs_zero: 1'b1}};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  slc_sample_path u_path (
    .clk        (clk),
    .resetn     (resetn),
    .ce         (ce),
    .link_rst_n (st_r.ctrl.link_rst_n),
    .ts_insert  (st_r.ctrl.ts_insert),
    .smp_in     (smp_in),
    .word_out   (word_out)
  );

  assign ctrl     = st_r.ctrl;
  assign mf_count = st_r.cnt;
  assign mf_edge  = st_r.edge_p;
endmodule

// >>> rtl/slc_pkg.sv
// package for the serial link control register bank
package slc_pkg;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned SAMPLE_W   = 16;
  localparam int unsigned ADC_W      = 12;
  localparam int unsigned PIPE_DEPTH = 2;

  localparam logic [11:0] OFS_LSB_CTRL = 12'h160;
  localparam logic [11:0] OFS_LINK_EN  = 12'h200;
  localparam logic [11:0] OFS_MODE     = 12'h201;
  localparam logic [11:0] OFS_KM1      = 12'h202;

  localparam logic [7:0] RST_LSB_CTRL = 8'h00;
  localparam logic [7:0] RST_LINK_EN  = 8'h01;
  localparam logic [7:0] RST_MODE     = 8'h00;
  localparam logic [7:0] RST_KM1      = 8'h1f;

  localparam int unsigned BIT_TS_INSERT = 0;
  localparam int unsigned BIT_LINK_EN   = 0;
  localparam int unsigned MODE_LO       = 0;
  localparam int unsigned MODE_W        = 6;
  localparam logic [15:0] BLOCK_FACTOR  = 16'h0100;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } slc_bus_type;

  typedef struct packed {
    logic              valid;
    logic [ADC_W-1:0]  data;
    logic              ts;
  } slc_sample_type;

  typedef struct packed {
    logic              valid;
    logic [SAMPLE_W-1:0] word;
  } slc_word_type;

  typedef struct packed {
    logic       link_rst_n;
    logic       serdes_pd;
    logic       clk_gate_en;
    logic       mfc_rst;
    logic       ts_insert;
    logic [5:0] mode;
    logic [7:0] k_eff_m1;
    logic       ila_cs_zero;
  } slc_ctrl_type;
endpackage

// >>> rtl/slc_regs.sv
// register storage and read port for the serial link control bank
module slc_regs
  import slc_pkg::*;
(
  // clocking
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  // bus
  input  wire slc_pkg::slc_bus_type bus,
  output logic [7:0]        rdata,
  // fields
  output logic [7:0]        lsb_ctrl,
  output logic [7:0]        link_en_reg,
  output logic [7:0]        mode_reg,
  output logic [7:0]        km1_reg
);
  typedef struct packed {
    logic [7:0] lsb;
    logic [7:0] en;
    logic [7:0] mode;
    logic [7:0] km1;
    logic [7:0] rdata;
  } slc_regs_state_type;

  slc_regs_state_type st_r;
  slc_regs_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (bus.wr) begin
      // whole byte kept, reserved bits included
      case (bus.addr)
        OFS_LSB_CTRL: st_nxt.lsb = bus.wdata;
        OFS_LINK_EN:  st_nxt.en = bus.wdata;
        OFS_MODE:     st_nxt.mode = bus.wdata;
        OFS_KM1:      st_nxt.km1 = bus.wdata;
        default:      st_nxt.lsb = st_r.lsb;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        OFS_LSB_CTRL: st_nxt.rdata = st_r.lsb;
        OFS_LINK_EN:  st_nxt.rdata = st_r.en;
        OFS_MODE:     st_nxt.rdata = st_r.mode;
        OFS_KM1:      st_nxt.rdata = st_r.km1;
        default:      st_nxt.rdata = 8'h00;
      endcase
    end else begin
      st_nxt.rdata = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{lsb: RST_LSB_CTRL, en: RST_LINK_EN, mode: RST_MODE, km1: RST_KM1, rdata: 8'h00};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign rdata       = st_r.rdata;
  assign lsb_ctrl    = st_r.lsb;
  assign link_en_reg = st_r.en;
  assign mode_reg    = st_r.mode;
  assign km1_reg     = st_r.km1;
endmodule

// >>> rtl/slc_sample_path.sv
// sample pipeline with timestamp placement on the link word lsb
module slc_sample_path
  import slc_pkg::*;
(
  // clocking
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic         link_rst_n,
  // control
  input  wire logic         ts_insert,
  // data
  input  wire slc_pkg::slc_sample_type smp_in,
  output slc_pkg::slc_word_type        word_out
);
  typedef struct packed {
    slc_sample_type [PIPE_DEPTH-1:0] pipe;
    slc_word_type                    out;
  } slc_path_state_type;

  slc_path_state_type st_r;
  slc_path_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.pipe[0] = smp_in;
    for (int i = 1; i < PIPE_DEPTH; i++) begin
      st_nxt.pipe[i] = st_r.pipe[i-1];
    end
    st_nxt.out.valid = st_r.pipe[PIPE_DEPTH-1].valid;
    // adc bits sit above lsb field
    st_nxt.out.word = {st_r.pipe[PIPE_DEPTH-1].data, {(SAMPLE_W-ADC_W){1'b0}}};
    if (ts_insert) begin
      st_nxt.out.word[0] = st_r.pipe[PIPE_DEPTH-1].ts;
    end
    if (!link_rst_n) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign word_out = st_r.out;
endmodule

// >>> verification/slc_checker.sv
// port-level assertions for the serial link control bank
module slc_checker
  import slc_pkg::*;
(
  // clocking and register port
  input wire logic                    clk,
  input wire logic                    resetn,
  input wire logic                    ce,
  input wire logic [11:0]             addr,
  input wire logic [7:0]              wdata,
  input wire logic                    wr,
  input wire logic                    rd,
  input wire logic [7:0]              rdata,
  // framing, samples and control
  input wire logic                    sysref,
  input wire logic                    is_64b66b,
  input wire logic [7:0]              mode_e,
  input wire logic [7:0]              mode_f,
  input wire slc_pkg::slc_sample_type smp_in,
  input wire slc_pkg::slc_word_type   word_out,
  input wire slc_pkg::slc_ctrl_type   ctrl,
  input wire logic [9:0]              mf_count,
  input wire logic                    mf_edge
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence run_s; ctrl.link_rst_n && !ctrl.mfc_rst; endsequence
  // sysref may be registered once inside, so both cycles must be quiet
  sequence calm_s; !sysref && !$past(sysref); endsequence

  rd_idle_a: assert property (ce && !rd |=> rdata == 8'h00)
    else $error("read data not idle");
  ila_zero_a: assert property (ctrl.ila_cs_zero)
    else $error("control bits advertised");
  link_off_a: assert property (!ctrl.link_rst_n |-> ctrl.serdes_pd && !ctrl.clk_gate_en && ctrl.mfc_rst)
    else $error("disabled link not held");
  mf_hold_a: assert property (ctrl.mfc_rst [*2] |-> mf_count == 10'h000 && !mf_edge)
    else $error("multiframe counter moved");
  word_map_a: assert property ((ctrl.link_rst_n && $stable(ctrl.ts_insert)) [*4] |->
    word_out == {$past(smp_in.valid, 3), $past(smp_in.data, 3), 3'h0, $past(smp_in.ts, 3) & ctrl.ts_insert})
    else $error("output word wrong");
  // ctrl lags the enable register a cycle, so the link must still be live one cycle on
  mf_wrap_a: assert property ((run_s and calm_s and mf_count == {2'b00, ctrl.k_eff_m1}) ##1 ctrl.link_rst_n |->
    mf_count == 10'h000 && mf_edge)
    else $error("multiframe wrap wrong");
  mf_step_a: assert property ((run_s and calm_s and mf_count < {2'b00, ctrl.k_eff_m1} and $stable(ctrl.k_eff_m1))
    ##1 ctrl.link_rst_n |-> mf_count == $past(mf_count) + 10'h001 && !mf_edge)
    else $error("multiframe step wrong");
  sysref_sync_a: assert property ((run_s and sysref) ##1 ctrl.link_rst_n |-> ##[0:1] mf_edge)
    else $error("sysref ignored");
endmodule

bind slc_top slc_checker u_slc_checker (.*);

// >>> verification/tb.sv
// self-checking bench for the serial link control bank
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import slc_pkg::*;
  logic           clk, resetn, ce, wr, rd, sysref, is_64b66b, mf_edge;
  logic [11:0]    addr;
  logic [7:0]     wdata, rdata, mode_e, mode_f;
  logic [9:0]     mf_count;
  slc_sample_type smp_in, s;
  slc_word_type   word_out;
  slc_ctrl_type   ctrl;
  int             fails, n_tests, m[int];
  logic [16:0]    q[$];

  slc_top u_slc_top (.*);

  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end

  task automatic chk_out(logic [16:0] got, logic [16:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(logic [7:0] got, logic [7:0] exp);
    chk_out({9'h000, got}, {9'h000, exp});
  endtask

  task automatic wr_reg(logic [11:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
    if (m.exists(a)) m[a] = d;
  endtask

  task automatic rd_reg(logic [11:0] a);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    @(negedge clk);
    chk_rd(rdata, m.exists(a) ? 8'(m[a]) : 8'h00);
  endtask

  // control outputs lag the register by one cycle
  task automatic ctl_chk;
    int k;
    @(negedge clk);
    @(negedge clk);
    k = is_64b66b ? 256 * mode_e / mode_f - 1 : m[12'h202];
    chk_out({ctrl.link_rst_n, ctrl.serdes_pd, ctrl.ts_insert, ctrl.mode, ctrl.k_eff_m1},
            {m[12'h200][0], !m[12'h200][0], m[12'h160][0], 6'(m[12'h201]), 8'(k)});
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    test_done;
  end

  initial begin
    resetn = 0;
    ce = 1;
    {wr, rd, sysref, is_64b66b, addr, wdata, smp_in} = '0;
    mode_e = 8'h01;
    mode_f = 8'h01;
    m[12'h160] = 8'h00;
    m[12'h200] = 8'h01;
    m[12'h201] = 8'h00;
    m[12'h202] = 8'h1f;
    void'($urandom(32'h641e71da));
    repeat (4) @(posedge clk);
    resetn <= 1;
    foreach (m[a]) rd_reg(12'(a));
    rd_reg(12'h203);
    $display("reset values done");
    repeat (6) foreach (m[a]) begin
      wr_reg(12'h203, 8'($urandom));
      wr_reg(12'h200, 8'h00);
      wr_reg(12'(a), 8'($urandom) & (a == 'h202 ? 8'hff : a == 'h201 ? 8'h3f : 8'h01));
      rd_reg(12'(a));
    end
    $display("read back done");
    for (int i = 0; i < 4; i++) begin
      wr_reg(12'h200, 8'h00);
      ctl_chk;
      sysref <= 1;
      @(posedge clk);
      sysref <= 0;
      @(negedge clk);
      chk_out({7'h00, mf_count}, 17'h00000);
      is_64b66b <= i[0];
      mode_e <= 8'(i + 1);
      mode_f <= 8'(1 << i);
      wr_reg(12'h201, {2'b00, 6'($urandom)});
      wr_reg(12'h202, 8'($urandom)); // mode table not modelled, any k accepted
      wr_reg(12'h160, 8'h00);
      wr_reg(12'h200, 8'h01);
      ctl_chk;
      repeat (300) @(posedge clk);
      sysref <= 1;
      @(posedge clk);
      sysref <= 0;
      @(negedge clk);
      chk_out({6'h00, mf_edge, mf_count}, 17'h00400);
      repeat (20) @(posedge clk);
    end
    $display("link control done");
    for (int j = 0; j < 2; j++) begin
      wr_reg(12'h200, 8'h00);
      wr_reg(12'h160, 8'(1 - j)); // receiver enable lives outside this bank
      wr_reg(12'h200, 8'h01); // calibration enable assumed already set
      repeat (4) @(posedge clk);
      q.delete();
      for (int i = 0; i < 40; i++) begin
        @(posedge clk);
        s = slc_sample_type'($urandom);
        smp_in <= s;
        q.push_back({s.valid, s.data, 3'h0, s.ts & m[12'h160][0]});
        @(negedge clk);
        if (q.size() > 3) chk_out(word_out, q.pop_front());
      end
    end
    $display("timestamp stream done");
    test_done;
  end
endmodule
